// *** include/ocdc_defines.svh ***
/*
 Register map, field positions, reset values and codes of the output
 channel divider and control block.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef OCDC_DEFINES_SVH
`define OCDC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices and APB byte addresses (index times four)
// ----------------------------------------------------------------
`define OCDC_IDX_DIV4 8'h26
`define OCDC_IDX_CTL5 8'h27
`define OCDC_IDX_SRC4 8'h30
`define OCDC_ADDR_DIV4 8'h98
`define OCDC_ADDR_CTL5 8'h9C
`define OCDC_ADDR_SRC4 8'hC0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCDC_RST_DIV4 8'h02
`define OCDC_RST_CTL5 8'h18
`define OCDC_RST_SRC4 2'h0

// ----------------------------------------------------------------
// Field positions inside the channel 5 control register
// ----------------------------------------------------------------
`define OCDC_SRC_HI 7
`define OCDC_SRC_LO 6
`define OCDC_FMT_HI 5
`define OCDC_FMT_LO 4
`define OCDC_DRVA_HI 3
`define OCDC_DRVA_LO 2
`define OCDC_DRVB_HI 1
`define OCDC_DRVB_LO 0

// ----------------------------------------------------------------
// Driver mode code points and analog settings
// ----------------------------------------------------------------
`define OCDC_PIN_OFF_Z 2'h0
`define OCDC_PIN_OFF_LOW 2'h1
`define OCDC_PIN_INV 2'h2
`define OCDC_PIN_TRUE 2'h3
`define OCDC_TAIL_0 5'h04
`define OCDC_TAIL_1 5'h06
`define OCDC_TAIL_2 5'h08
`define OCDC_TAIL_3_HCSL 5'h10
`define OCDC_TAIL_3_AC 5'h08
`define OCDC_LOAD_1 8'h32
`define OCDC_LOAD_2 8'h64
`define OCDC_LOAD_3 8'hC8

`endif

// *** include/ocdc_pkg.sv ***
/*
 Types shared by the output channel divider and control block.
 Assumes ocdc_defines.svh is on the include path.
*/
package ocdc_pkg;

  // Clock source select codes; code 1 is reserved
  typedef enum logic [1:0] {
    OCDC_SRC_SYNTH = 2'h0,
    OCDC_SRC_RSVD = 2'h1,
    OCDC_SRC_PRIM = 2'h2,
    OCDC_SRC_SEC = 2'h3
  } ocdc_src_t;

  // Driver format codes
  typedef enum logic [1:0] {
    OCDC_FMT_OFF = 2'h0,
    OCDC_FMT_AC = 2'h1,
    OCDC_FMT_HCSL = 2'h2,
    OCDC_FMT_CMOS = 2'h3
  } ocdc_fmt_t;

endpackage

// *** include/ocdc_div_if.sv ***
/*
 Link between the register side and the channel 4 divider.
 Assumes both ends run on the same clock and clock enable.
*/
`timescale 1ns/1ns
interface ocdc_div_if;
  logic ce;
  logic run;
  logic [7:0] ratio;
  logic src_clk;
  logic pulse;

  modport ctl (output ce, output run, output ratio, output src_clk,
               input pulse);
  modport div (input ce, input run, input ratio, input src_clk,
               output pulse);
endinterface

// *** design/ocdc_clk_div.sv ***
/*
 Channel 4 divider: counts rising edges of the sampled synthesizer
 clock and emits a one-cycle pulse every ratio plus one edges.
 Assumes the synthesizer clock level is synchronous to clock_i.
*/
`timescale 1ns/1ns
`include "ocdc_defines.svh"
module ocdc_clk_div (
  input wire logic clock_i,
  input wire logic rst_i,
  ocdc_div_if.div dif
);

  logic prev_ff;
  logic [7:0] cnt_ff;
  logic pulse_ff;
  logic [7:0] nxt_cnt;
  logic nxt_pulse;

  // ----------------------------------------------------------------
  // Edge count
  // ----------------------------------------------------------------
  // Held at zero while idle so a restart gives a full first period
  wire src_edge = dif.src_clk & ~prev_ff;
  wire at_end = (cnt_ff >= dif.ratio);
  assign nxt_cnt = !dif.run ? 8'h00 :
                   !src_edge ? cnt_ff :
                   at_end ? 8'h00 : cnt_ff + 8'h01;
  assign nxt_pulse = dif.run & src_edge & at_end;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ff <= 1'b0;
      cnt_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end else if (dif.ce) begin
      prev_ff <= dif.src_clk;
      cnt_ff <= nxt_cnt;
      pulse_ff <= nxt_pulse;
    end
  end

  assign dif.pulse = pulse_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DIV_WRAP: assert property (@(posedge clock_i) disable iff (rst_i)
    dif.ce && dif.run && src_edge && cnt_ff == dif.ratio
      |=> pulse_ff && cnt_ff == 8'h00)
    else $error("Divider did not wrap at the ratio");
  AST_DIV_IDLE: assert property (@(posedge clock_i) disable iff (rst_i)
    dif.ce && !dif.run |=> !pulse_ff && cnt_ff == 8'h00)
    else $error("Divider active without synthesizer source");
  COV_DIV_BY1: cover property (@(posedge clock_i) disable iff (rst_i)
    dif.ce && dif.run && dif.ratio == 8'h00 && nxt_pulse);

endmodule // ocdc_clk_div

// *** design/ocdc_top.sv ***
/*
 Output channel divider and control: APB register file holding the
 channel 4 divider, a channel 4 source select and the channel 5
 output control, plus the source muxes and output driver settings.
 Assumes reference and synthesizer clock levels are synchronous to
 clock_i; the analog buffer consumes the driver setting outputs.
*/
`timescale 1ns/1ns
`include "ocdc_defines.svh"
module ocdc_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic synth_clk_i,
  input wire logic prim_ref_i,
  input wire logic sec_ref_i,
  output logic ch4_clk_o,
  output logic ch5_p_o,
  output logic ch5_p_oe_o,
  output logic ch5_n_o,
  output logic ch5_n_oe_o,
  output logic [1:0] ch5_format_o,
  output logic [4:0] ch5_tail_ma_o,
  output logic [7:0] ch5_load_ohm_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] div4_ff;
  logic [7:0] ctl5_ff;
  logic [1:0] src4_ff;
  logic [31:0] rdata_ff;
  logic ch4_clk_ff;
  logic p_ff, p_oe_ff, n_ff, n_oe_ff;
  logic [4:0] tail_ff;
  logic [7:0] load_ff;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Address phase is the setup cycle; writes land on the access edge
  wire hit_div4 = (paddr_i == `OCDC_ADDR_DIV4);
  wire hit_ctl5 = (paddr_i == `OCDC_ADDR_CTL5);
  wire hit_src4 = (paddr_i == `OCDC_ADDR_SRC4);
  wire hit_any = hit_div4 | hit_ctl5 | hit_src4;
  wire access = psel_i & penable_i & ce_i;
  wire wr_div4 = access & pwrite_i & hit_div4;
  wire wr_ctl5 = access & pwrite_i & hit_ctl5;
  wire wr_src4 = access & pwrite_i & hit_src4;
  wire setup_rd = psel_i & ~penable_i & ~pwrite_i & ce_i;
  logic [31:0] nxt_rdata;
  assign nxt_rdata = hit_div4 ? {24'h0000_00, div4_ff} :
                     hit_ctl5 ? {24'h0000_00, ctl5_ff} :
                     hit_src4 ? {30'h0000_0000, src4_ff} :
                     32'h0000_0000;

  // Stall the master while the block is frozen so no write is lost
  assign pready_o = ce_i;
  assign pslverr_o = psel_i & penable_i & ~hit_any;
  assign prdata_o = rdata_ff;

  // Register writes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div4_ff <= `OCDC_RST_DIV4;
      ctl5_ff <= `OCDC_RST_CTL5;
      src4_ff <= `OCDC_RST_SRC4;
    end else begin
      if (wr_div4) div4_ff <= pwdata_i[7:0];
      if (wr_ctl5) ctl5_ff <= pwdata_i[7:0];
      if (wr_src4) src4_ff <= pwdata_i[1:0];
    end
  end

  // Read data captured in the setup cycle, steady through access
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) rdata_ff <= 32'h0000_0000;
    else if (setup_rd) rdata_ff <= nxt_rdata;
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  ocdc_pkg::ocdc_src_t src5;
  ocdc_pkg::ocdc_src_t src4;
  ocdc_pkg::ocdc_fmt_t fmt5;
  wire [1:0] drv_a = ctl5_ff[`OCDC_DRVA_HI:`OCDC_DRVA_LO];
  wire [1:0] drv_b = ctl5_ff[`OCDC_DRVB_HI:`OCDC_DRVB_LO];
  assign src5 = ocdc_pkg::ocdc_src_t'(ctl5_ff[`OCDC_SRC_HI:`OCDC_SRC_LO]);
  assign src4 = ocdc_pkg::ocdc_src_t'(src4_ff);
  assign fmt5 = ocdc_pkg::ocdc_fmt_t'(ctl5_ff[`OCDC_FMT_HI:`OCDC_FMT_LO]);

  // ----------------------------------------------------------------
  // Source muxes
  // ----------------------------------------------------------------
  // Reserved code gives a quiet low rather than an undefined clock;
  // every level is an argument so the muxes follow all their inputs
  function automatic logic pick(input ocdc_pkg::ocdc_src_t s,
                                input logic syn,
                                input logic pri,
                                input logic sec);
    logic r;
    r = 1'b0;
    if (s == ocdc_pkg::OCDC_SRC_SYNTH) r = syn;
    else if (s == ocdc_pkg::OCDC_SRC_PRIM) r = pri;
    else if (s == ocdc_pkg::OCDC_SRC_SEC) r = sec;
    return r;
  endfunction

  ocdc_div_if dif ();
  wire ch4_synth = (src4 == ocdc_pkg::OCDC_SRC_SYNTH);
  assign dif.ce = ce_i;
  assign dif.run = ch4_synth;
  assign dif.ratio = div4_ff;
  assign dif.src_clk = synth_clk_i;

  ocdc_clk_div u_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .dif(dif)
  );

  // References bypass the divider altogether
  wire ch4_ref = pick(src4, 1'b0, prim_ref_i, sec_ref_i);
  wire ch4_lvl = ch4_synth ? dif.pulse : ch4_ref;
  wire ch5_lvl = pick(src5, synth_clk_i, prim_ref_i, sec_ref_i);

  // ----------------------------------------------------------------
  // Channel 5 driver
  // ----------------------------------------------------------------
  // One pin of the LVCMOS pair from its two-bit mode code
  function automatic logic [1:0] cmos_pin(input logic [1:0] code,
                                          input logic lvl);
    logic [1:0] r;
    r = 2'b00;
    case (code)
      `OCDC_PIN_OFF_Z: r = 2'b00;
      `OCDC_PIN_OFF_LOW: r = 2'b10;
      `OCDC_PIN_INV: r = {1'b1, ~lvl};
      default: r = {1'b1, lvl};
    endcase
    return r;
  endfunction

  logic [1:0] pin_p, pin_n;
  logic [4:0] nxt_tail;
  logic [7:0] nxt_load;
  wire is_diff = (fmt5 == ocdc_pkg::OCDC_FMT_AC) |
                 (fmt5 == ocdc_pkg::OCDC_FMT_HCSL);
  wire is_cmos = (fmt5 == ocdc_pkg::OCDC_FMT_CMOS);
  wire is_hcsl = (fmt5 == ocdc_pkg::OCDC_FMT_HCSL);
  wire [1:0] cm_p = cmos_pin(drv_a, ch5_lvl);
  wire [1:0] cm_n = cmos_pin(drv_b, ch5_lvl);

  // Pin enable in bit 1, level in bit 0
  assign pin_p = is_cmos ? cm_p :
                 is_diff ? {1'b1, ch5_lvl} : 2'b00;
  assign pin_n = is_cmos ? cm_n :
                 is_diff ? {1'b1, ~ch5_lvl} : 2'b00;

  // Tail current in mA; zero when not differential
  assign nxt_tail = !is_diff ? 5'h00 :
                    drv_a == 2'h0 ? `OCDC_TAIL_0 :
                    drv_a == 2'h1 ? `OCDC_TAIL_1 :
                    drv_a == 2'h2 ? `OCDC_TAIL_2 :
                    is_hcsl ? `OCDC_TAIL_3_HCSL : `OCDC_TAIL_3_AC;

  // HCSL load in ohms; zero means tristate
  assign nxt_load = !is_diff ? 8'h00 :
                    drv_b == 2'h1 ? `OCDC_LOAD_1 :
                    drv_b == 2'h2 ? `OCDC_LOAD_2 :
                    drv_b == 2'h3 ? `OCDC_LOAD_3 : 8'h00;

  // Output flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ch4_clk_ff <= 1'b0;
      {p_oe_ff, p_ff} <= 2'b00;
      {n_oe_ff, n_ff} <= 2'b00;
      tail_ff <= 5'h00;
      load_ff <= 8'h00;
    end else if (ce_i) begin
      ch4_clk_ff <= ch4_lvl;
      {p_oe_ff, p_ff} <= pin_p;
      {n_oe_ff, n_ff} <= pin_n;
      tail_ff <= nxt_tail;
      load_ff <= nxt_load;
    end
  end

  assign ch4_clk_o = ch4_clk_ff;
  assign ch5_p_o = p_ff;
  assign ch5_p_oe_o = p_oe_ff;
  assign ch5_n_o = n_ff;
  assign ch5_n_oe_o = n_oe_ff;
  assign ch5_format_o = fmt5;
  assign ch5_tail_ma_o = tail_ff;
  assign ch5_load_ohm_o = load_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_CH4_BYPASS: assert property (
    ce_i && src4 == ocdc_pkg::OCDC_SRC_SEC && src4_ff == $past(src4_ff)
      |=> ch4_clk_o == $past(sec_ref_i))
    else $error("Channel 4 reference not bypassed");
  AST_SRC_PRIM: assert property (
    ce_i && src5 == ocdc_pkg::OCDC_SRC_PRIM && is_diff
      |=> ch5_p_o == $past(prim_ref_i) && ch5_n_o != ch5_p_o)
    else $error("Channel 5 primary reference not routed");
  AST_FMT_OFF: assert property (
    ce_i && fmt5 == ocdc_pkg::OCDC_FMT_OFF
      |=> !ch5_p_oe_o && !ch5_n_oe_o && ch5_tail_ma_o == 5'h00)
    else $error("Disabled output still driving");
  AST_TAIL_HCSL: assert property (
    ce_i && is_hcsl && drv_a == 2'h3 |=> ch5_tail_ma_o == 5'h10)
    else $error("HCSL tail current not 16 mA");
  AST_TAIL_AC: assert property (
    ce_i && fmt5 == ocdc_pkg::OCDC_FMT_AC && drv_a == 2'h0
      |=> ch5_tail_ma_o == 5'h04)
    else $error("AC tail current not 4 mA");
  AST_P_LOW: assert property (
    ce_i && is_cmos && drv_a == 2'h1 |=> ch5_p_oe_o && !ch5_p_o)
    else $error("Positive pin not powered down low");
  AST_N_INV: assert property (
    ce_i && is_cmos && drv_b == 2'h2
      |=> ch5_n_oe_o && ch5_n_o == !$past(ch5_lvl))
    else $error("Negative pin not inverted");
  AST_LOAD_200: assert property (
    ce_i && is_hcsl && drv_b == 2'h3 |=> ch5_load_ohm_o == 8'hC8)
    else $error("HCSL load not 200 ohm");
  AST_WR_DIV: assert property (
    wr_div4 |=> div4_ff == $past(pwdata_i[7:0]) ##1 dif.ratio == div4_ff)
    else $error("Divider write not taken");

  COV_HCSL: cover property (ce_i && is_hcsl && drv_a == 2'h3);
  COV_CMOS: cover property (ce_i && is_cmos && drv_a == 2'h2);
  COV_SEC4: cover property (ce_i && src4 == ocdc_pkg::OCDC_SRC_SEC);
  COV_ERR: cover property (pslverr_o);

endmodule // ocdc_top

// *** sim/ocdc_top_tb_top.sv ***
/*
 Self-checking bench for the output channel divider and control block:
 APB register access, channel 4 divider and channel 5 driver settings.
 Assumes include/ on the include path and the design files compiled.
*/
`timescale 1ns/1ns
`include "ocdc_defines.svh"
module ocdc_top_tb_top;
  // ----------------------------------------------------------------
  // Stimulus, observed ports and expectation queues
  // ----------------------------------------------------------------
  typedef struct {logic [35:0] e; logic [35:0] m;} ocdc_note_t;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, snap = 1'b0;
  logic synth = 1'b0, prim = 1'b0, sec = 1'b0, pclr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ch4, p, poe, n, noe;
  logic [1:0] fmt;
  logic [4:0] tail;
  logic [7:0] load;
  logic [15:0] pcnt = 16'h0000;
  ocdc_note_t rq[$], oq[$];
  int err_count = 0;
  int n_tests = 0;

  always #5 clock_i = ~clock_i;

  ocdc_top uut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .synth_clk_i(synth),
    .prim_ref_i(prim), .sec_ref_i(sec), .ch4_clk_o(ch4), .ch5_p_o(p),
    .ch5_p_oe_o(poe), .ch5_n_o(n), .ch5_n_oe_o(noe),
    .ch5_format_o(fmt), .ch5_tail_ma_o(tail), .ch5_load_ohm_o(load));

  // ----------------------------------------------------------------
  // Monitor: one note is consumed per completed access or snapshot
  // ----------------------------------------------------------------
  task automatic judge(input ocdc_note_t nt, input logic [35:0] obs);
    n_tests++;
    if ((obs & nt.m) !== (nt.e & nt.m)) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, obs, nt.e);
    end
  endtask

  // Masked compare lets unknowns fail while skipping undefined levels
  always @(posedge clock_i) begin
    if (psel && penable && pready === 1'b1)
      judge(rq.pop_front(), {3'b000, pslverr, prdata});
    if (snap)
      judge(oq.pop_front(), {pcnt, ch4, p, poe, n, noe, fmt, tail, load});
  end

  // Divider pulse counter, cleared by the driver before each run
  always @(posedge clock_i) begin
    if (pclr)
      pcnt <= 16'h0000;
    else if (ch4 === 1'b1)
      pcnt <= pcnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic err, input logic stall);
    ocdc_note_t nt;
    int w;
    nt.e = {3'b000, err, x};
    nt.m = {4'h1, wr ? 32'h0000_0000 : 32'hFFFF_FFFF};
    rq.push_back(nt);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // Clock enable low must hold the access open
    if (stall) begin
      ce_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      ce_i <= 1'b1;
    end
    w = 0;
    do begin
      @(posedge clock_i);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) begin
      err_count++;
      $display("CHECK FAILED at %0t: access never completed", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic look(input logic [35:0] e, input logic [35:0] m);
    ocdc_note_t nt;
    nt.e = e;
    nt.m = m;
    oq.push_back(nt);
    @(posedge clock_i);
    snap <= 1'b1;
    @(posedge clock_i);
    snap <= 1'b0;
  endtask

  // Pin level, enable, and whether the level is defined
  function automatic logic [2:0] pin(input logic [1:0] c, input logic l);
    case (c)
      2'h0: pin = 3'b000;
      2'h1: pin = 3'b011;
      2'h2: pin = {~l, 2'b11};
      default: pin = {l, 2'b11};
    endcase
  endfunction

  // Counter starts from zero because a reference source holds it
  task automatic div_case(input logic [1:0] s, input logic [7:0] nv,
                          input int edges, input int k);
    prim <= 1'b0;
    synth <= 1'b0;
    apb(1'b1, `OCDC_ADDR_SRC4, 32'h0000_0002, 32'h0, 1'b0, 1'b0);
    apb(1'b1, `OCDC_ADDR_DIV4, {24'h00_0000, nv}, 32'h0, 1'b0, 1'b0);
    apb(1'b1, `OCDC_ADDR_SRC4, {30'h0, s}, 32'h0, 1'b0, 1'b0);
    pclr <= 1'b1;
    @(posedge clock_i);
    pclr <= 1'b0;
    repeat (edges) begin
      synth <= 1'b1;
      @(posedge clock_i);
      synth <= 1'b0;
      @(posedge clock_i);
    end
    repeat (4) @(posedge clock_i);
    look({16'(k), 20'h0_0000}, 36'hF_FFF8_0000);
  endtask

  task automatic ctl5_case(input logic [7:0] v);
    logic [2:0] r, pa, pb;
    logic l;
    logic [35:0] e, m;
    r = 3'($urandom);
    synth <= r[0];
    prim <= r[1];
    sec <= r[2];
    apb(1'b1, `OCDC_ADDR_CTL5, {24'h00_0000, v}, 32'h0, 1'b0, 1'b0);
    repeat (3) @(posedge clock_i);
    case (v[7:6])
      2'h0: l = r[0];
      2'h2: l = r[1];
      2'h3: l = r[2];
      default: l = 1'b0;
    endcase
    e = {21'h0, v[5:4], 13'h0000};
    m = 36'h0_0000_7FFF;
    pa = pin(v[3:2], l);
    pb = pin(v[1:0], l);
    case (v[5:4])
      2'h0: m[17] = 1'b1;
      2'h3: begin
        e[18:15] = {pa[2:1], pb[2:1]};
        m[18:15] = {pa[0], 1'b1, pb[0], 1'b1};
      end
      default: begin
        e[18:15] = {l, 1'b1, ~l, 1'b1};
        m[18:15] = 4'hF;
        case (v[3:2])
          2'h0: e[12:8] = 5'h04;
          2'h1: e[12:8] = 5'h06;
          2'h2: e[12:8] = 5'h08;
          default: e[12:8] = (v[5:4] == 2'h2) ? 5'h10 : 5'h08;
        endcase
        case (v[1:0])
          2'h1: e[7:0] = 8'h32;
          2'h2: e[7:0] = 8'h64;
          2'h3: e[7:0] = 8'hC8;
          default: e[7:0] = 8'h00;
        endcase
        if (v[5:4] == 2'h1)
          m[7:0] = 8'h00;
      end
    endcase
    if (v[5:4] == 2'h0)
      m[15] = 1'b1;
    look(e, m);
  endtask

  // ----------------------------------------------------------------
  // Main sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Checks made: %0d, mismatches: %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] nv;
    void'($urandom(36));
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    apb(1'b0, `OCDC_ADDR_DIV4, 32'h0, 32'h0000_0002, 1'b0, 1'b0);
    apb(1'b0, `OCDC_ADDR_CTL5, 32'h0, 32'h0000_0018, 1'b0, 1'b0);
    apb(1'b0, `OCDC_ADDR_SRC4, 32'h0, 32'h0000_0000, 1'b0, 1'b1);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF, 32'h0, 1'b1, 1'b0);
    apb(1'b0, 8'h40, 32'h0, 32'h0000_0000, 1'b1, 1'b0);
    apb(1'b1, `OCDC_ADDR_DIV4, 32'h0000_00A5, 32'h0, 1'b0, 1'b1);
    apb(1'b0, `OCDC_ADDR_DIV4, 32'h0, 32'h0000_00A5, 1'b0, 1'b0);
    div_case(2'h0, 8'h00, 6, 6);
    div_case(2'h0, 8'hFF, 512, 2);
    nv = 8'($urandom_range(40, 1));
    div_case(2'h0, nv, 3 * (int'(nv) + 1), 3);
    div_case(2'h2, 8'h01, 20, 0);
    // Reference level is passed straight to channel 4
    prim <= 1'b1;
    repeat (3) @(posedge clock_i);
    look(36'h0_0008_0000, 36'h0_0008_0000);
    // Secondary reference reaches channel 4 the same way
    prim <= 1'b0;
    sec <= 1'b1;
    apb(1'b1, `OCDC_ADDR_SRC4, 32'h0000_0003, 32'h0, 1'b0, 1'b0);
    repeat (3) @(posedge clock_i);
    look(36'h0_0008_0000, 36'h0_0008_0000);
    // Software never writes the reserved source code
    for (int i = 0; i < 256; i++)
      if (i[7:6] != 2'h1)
        ctl5_case(8'(i));
    tally_and_finish;
  end

  initial begin
    #500000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish;
  end
endmodule // ocdc_top_tb_top
